// ==== design/dtc_pkg.sv ====
// Constants and carrier types for the dual timer/counter block.
// Assumes one 40 MHz system clock and a 32-bit Avalon-MM register bus.
package dtc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_TIMER_CTL = 8'h88;
	localparam logic [7:0] IDX_TIMER_MODE_CTL = 8'h89;
	localparam logic [7:0] IDX_TIMER0_LOW = 8'h8a;
	localparam logic [7:0] IDX_TIMER1_LOW = 8'h8b;
	localparam logic [7:0] IDX_TIMER0_HIGH = 8'h8c;
	localparam logic [7:0] IDX_TIMER1_HIGH = 8'h8d;
	localparam logic [7:0] IDX_CLOCK_SELECT_CTL = 8'h8e;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hf0;
	localparam logic [7:0] IDX_IRQ_CLEAR = 8'hf1;
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'hf2;

	// Timer control fields
	localparam int CTL_T1_OVF = 7;
	localparam int CTL_T1_RUN = 6;
	localparam int CTL_T0_OVF = 5;
	localparam int CTL_T0_RUN = 4;
	localparam int CTL_IRQ1_DET = 3;
	localparam int CTL_IRQ1_TYPE = 2;
	localparam int CTL_IRQ0_DET = 1;
	localparam int CTL_IRQ0_TYPE = 0;

	// Mode control fields, inside each timer's nibble
	localparam int MODE_T1_BASE = 4;
	localparam int MODE_T0_BASE = 0;
	localparam int MODE_GATE = 3;
	localparam int MODE_CT = 2;
	localparam int MODE_MSEL = 0;

	// Clock select fields
	localparam int CKS_T1_DIV4 = 4;
	localparam int CKS_T0_DIV4 = 3;

	// Reset values
	localparam logic [7:0] TIMER_CTL_RST = 8'h00;
	localparam logic [7:0] TIMER_MODE_RST = 8'h00;
	localparam logic [7:0] TIMER_BYTE_RST = 8'h00;
	localparam logic [7:0] CLOCK_SELECT_RST = 8'h01;
	localparam logic [3:0] IRQ_RST = 4'h0;

	// Count clock dividers, in system clocks
	localparam logic [3:0] DIV_SLOW = 4'hc;
	localparam logic [3:0] DIV_FAST = 4'h4;

	// Mode select codes
	localparam logic [1:0] MODE_13BIT = 2'h0;
	localparam logic [1:0] MODE_16BIT = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT = 2'h3;

	// Pins from outside the clock domain
	typedef struct packed {
		logic ext_irq_pin_b;
		logic ext_irq_pin_a;
		logic count_pin1;
		logic count_pin0;
	} dtc_pins_type;

	// One bit per interrupt source, also the status layout
	typedef struct packed {
		logic irq1;
		logic irq0;
		logic timer1;
		logic timer0;
	} dtc_src_type;

	// Result of one counting step
	typedef struct packed {
		logic [7:0] low;
		logic [7:0] high;
		logic ovf;
	} dtc_step_type;
endpackage

// ==== design/dtc_timer_block.sv ====
// Two timer/counters with external interrupt detect flags.
// Assumes pins are asynchronous, vector acks come from logic on clock_i,
// and an Avalon-MM master with word addresses drives the register bus.
`timescale 1ns/100ps

// How it works
// - Counter overflow sets that timer's overflow flag, bit 7 or bit 5, save timer 1's own while timer 0 is in mode 3.
// - Overflow flag clears on vector acknowledge; software may set or clear.
// - Run bits 6 and 4 switch timer 1 and timer 0 on or off.
// - Selected edge or level on interrupt pin sets detect flag 3 or 1.
// - Edge flags clear on vector acknowledge; level flags follow the pin.
// - Trigger type bits 2 and 0 choose falling edge or low level.
// - With gating set, count only while pin high and run bit set.
// - Select bit clear counts internal clock; set counts count-pin falls.
// - Mode 00 is an 8-bit counter behind a 5-bit prescaler.
// - Mode 01 is a full 16-bit counter of high and low bytes.
// - Mode 10 is an 8-bit counter reloaded from the high byte.
// - Mode 3 splits timer 0; high byte is a timer run by timer 1.
// - Timer 1 in mode 3 stops counting.
// - Clock select 1 counts clock divided by 4, else by 12.
// - Each count is readable and writable as low and high bytes.
module dtc_timer_block
	import dtc_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	// Register bus
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Far side and interrupt controller
	input wire dtc_pins_type pins_i,
	input wire dtc_src_type vector_ack_i,
	output dtc_src_type flags_o,
	output logic irq_o
);

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic dtc_step_type timer_step(
		input logic [1:0] mode,
		input logic [7:0] low,
		input logic [7:0] high,
		input logic inc
	);
		dtc_step_type s;
		logic [13:0] w13;
		logic [16:0] w16;
		logic [8:0] w8;
		s = '{low: low, high: high, ovf: 1'b0};
		w13 = {1'b0, high, low[4:0]} + 14'h0001;
		w16 = {1'b0, high, low} + 17'h00001;
		w8 = {1'b0, low} + 9'h001;
		if (inc) begin
			unique case (mode)
				MODE_13BIT: begin
					// Upper three low bits are not part of the count
					s.high = w13[12:5];
					s.low = {low[7:5], w13[4:0]};
					s.ovf = w13[13];
				end
				MODE_16BIT: begin
					s.high = w16[15:8];
					s.low = w16[7:0];
					s.ovf = w16[16];
				end
				MODE_RELOAD: begin
					s.low = w8[8] ? high : w8[7:0];
					s.ovf = w8[8];
				end
				MODE_SPLIT: begin
					// Timer 0 low byte; timer 1 is held off by the split_mode term of inc1
					s.low = w8[7:0];
					s.ovf = w8[8];
				end
			endcase
		end
		return s;
	endfunction

	// Divide-by-4 fires on counts 3, 7, 11; divide-by-12 on count 11
	function automatic logic count_tick(
		input logic fast,
		input logic [3:0] cnt
	);
		logic t;
		t = fast ? (cnt[1:0] == 2'(DIV_FAST - 4'h1)) :
			(cnt == DIV_SLOW - 4'h1);
		return t;
	endfunction

	// Timer 0 in mode 3 lends its high byte to timer 1's run bit
	function automatic logic split_mode(
		input logic [3:0] cfg
	);
		return cfg[MODE_MSEL +: 2] == MODE_SPLIT;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	dtc_pins_type pin_meta;
	dtc_pins_type pin_sync;
	dtc_pins_type pin_prev;
	logic [3:0] div_cnt;
	logic [3:0] next_div_cnt;
	logic [7:0] timer_ctl;
	logic [7:0] next_timer_ctl;
	logic [7:0] timer_mode_ctl;
	logic [7:0] next_timer_mode_ctl;
	logic [7:0] timer0_low_byte;
	logic [7:0] next_timer0_low_byte;
	logic [7:0] timer1_low_byte;
	logic [7:0] next_timer1_low_byte;
	logic [7:0] timer0_high_byte;
	logic [7:0] next_timer0_high_byte;
	logic [7:0] timer1_high_byte;
	logic [7:0] next_timer1_high_byte;
	logic [7:0] clock_select_ctl;
	logic [7:0] next_clock_select_ctl;
	dtc_src_type irq_status;
	dtc_src_type next_irq_status;
	dtc_src_type irq_enable;
	dtc_src_type next_irq_enable;
	logic next_irq;
	logic next_waitrequest;
	logic [31:0] next_readdata;

	// Working signals
	dtc_pins_type pin_fall;
	logic [3:0] t0_cfg;
	logic [3:0] t1_cfg;
	logic tick0;
	logic tick1;
	logic inc0;
	logic inc1;
	logic inc_split;
	logic [8:0] split_sum;
	dtc_step_type step0;
	dtc_step_type step1;
	logic ovf0;
	logic ovf1;
	logic commit;
	logic [7:0] wdata;
	dtc_src_type event_set;

	// ------------------------------------------------------------
	// Pin synchronisers and falling edges
	// ------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			// Idle-high reset level, so release shows no false fall
			pin_meta <= '1;
			pin_sync <= '1;
			pin_prev <= '1;
		end else begin
			pin_meta <= pins_i;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	always_comb begin
		pin_fall = pin_prev & ~pin_sync;
	end

	// ------------------------------------------------------------
	// Count clock divider
	// ------------------------------------------------------------
	always_comb begin
		// One divider serves both timers; /12 ticks are a subset of /4
		if (div_cnt == DIV_SLOW - 4'h1) begin
			next_div_cnt = 4'h0;
		end else begin
			next_div_cnt = div_cnt + 4'h1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			div_cnt <= 4'h0;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	// ------------------------------------------------------------
	// Counting
	// ------------------------------------------------------------
	always_comb begin
		t0_cfg = timer_mode_ctl[MODE_T0_BASE +: 4];
		t1_cfg = timer_mode_ctl[MODE_T1_BASE +: 4];
		tick0 = count_tick(clock_select_ctl[CKS_T0_DIV4], div_cnt);
		tick1 = count_tick(clock_select_ctl[CKS_T1_DIV4], div_cnt);
		// Count pins are taken once per fall, after both sync stages
		inc0 = timer_ctl[CTL_T0_RUN] &
			(~t0_cfg[MODE_GATE] | pin_sync.ext_irq_pin_a) &
			(t0_cfg[MODE_CT] ? pin_fall.count_pin0 : tick0);
		inc1 = timer_ctl[CTL_T1_RUN] &
			(~t1_cfg[MODE_GATE] | pin_sync.ext_irq_pin_b) &
			(t1_cfg[MODE_CT] ? pin_fall.count_pin1 : tick1) &
			~split_mode(t1_cfg);
		// Split high byte: internal clock only, run by timer 1's bit
		inc_split = split_mode(t0_cfg) &
			timer_ctl[CTL_T1_RUN] & tick0;
		split_sum = {1'b0, timer0_high_byte} + 9'(inc_split);
		// Both timers share one step function so the modes stay alike
		step0 = timer_step(t0_cfg[MODE_MSEL +: 2], timer0_low_byte,
			timer0_high_byte, inc0);
		step1 = timer_step(t1_cfg[MODE_MSEL +: 2], timer1_low_byte,
			timer1_high_byte, inc1);
		ovf0 = step0.ovf;
		// In split mode timer 1's own overflow loses its flag
		ovf1 = (step1.ovf & ~split_mode(t0_cfg)) |
			split_sum[8];
	end

	// ------------------------------------------------------------
	// Register file next values
	// ------------------------------------------------------------
	always_comb begin
		// A write lands at the edge where waitrequest is seen low
		commit = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
		wdata = avs_writedata_i[7:0];
		next_timer_mode_ctl = timer_mode_ctl;
		next_clock_select_ctl = clock_select_ctl;
		next_timer0_low_byte = step0.low;
		next_timer1_low_byte = step1.low;
		next_timer0_high_byte = split_mode(t0_cfg) ?
			split_sum[7:0] : step0.high;
		next_timer1_high_byte = step1.high;
		next_timer_ctl = timer_ctl;
		next_irq_enable = irq_enable;
		next_irq_status = irq_status;
		if (commit) begin
			// Software loads take priority over counting
			unique case (avs_address_i)
				IDX_TIMER_CTL: next_timer_ctl = wdata;
				IDX_TIMER_MODE_CTL: next_timer_mode_ctl = wdata;
				IDX_TIMER0_LOW: next_timer0_low_byte = wdata;
				IDX_TIMER1_LOW: next_timer1_low_byte = wdata;
				IDX_TIMER0_HIGH: next_timer0_high_byte = wdata;
				IDX_TIMER1_HIGH: next_timer1_high_byte = wdata;
				IDX_CLOCK_SELECT_CTL: next_clock_select_ctl = wdata;
				IDX_IRQ_ENABLE: next_irq_enable = wdata[3:0];
				IDX_IRQ_CLEAR: next_irq_status = irq_status & ~wdata[3:0];
				default: begin
				end
			endcase
		end
		// Overflow flags: ack clears, overflow sets and wins
		if (vector_ack_i.timer0) begin
			next_timer_ctl[CTL_T0_OVF] = 1'b0;
		end
		if (ovf0) begin
			next_timer_ctl[CTL_T0_OVF] = 1'b1;
		end
		if (vector_ack_i.timer1) begin
			next_timer_ctl[CTL_T1_OVF] = 1'b0;
		end
		if (ovf1) begin
			next_timer_ctl[CTL_T1_OVF] = 1'b1;
		end
		// Detect flags: type 1 is falling edge, type 0 is low level
		// Level-mode flags override software writes to them
		if (timer_ctl[CTL_IRQ0_TYPE]) begin
			if (vector_ack_i.irq0) begin
				next_timer_ctl[CTL_IRQ0_DET] = 1'b0;
			end
			if (pin_fall.ext_irq_pin_a) begin
				next_timer_ctl[CTL_IRQ0_DET] = 1'b1;
			end
		end else begin
			next_timer_ctl[CTL_IRQ0_DET] = ~pin_sync.ext_irq_pin_a;
		end
		if (timer_ctl[CTL_IRQ1_TYPE]) begin
			if (vector_ack_i.irq1) begin
				next_timer_ctl[CTL_IRQ1_DET] = 1'b0;
			end
			if (pin_fall.ext_irq_pin_b) begin
				next_timer_ctl[CTL_IRQ1_DET] = 1'b1;
			end
		end else begin
			next_timer_ctl[CTL_IRQ1_DET] = ~pin_sync.ext_irq_pin_b;
		end
		// Sticky status: a new event beats a clear in the same cycle
		event_set.timer0 = ovf0;
		event_set.timer1 = ovf1;
		event_set.irq0 = pin_fall.ext_irq_pin_a;
		event_set.irq1 = pin_fall.ext_irq_pin_b;
		next_irq_status = next_irq_status | event_set;
		next_irq = |(irq_status & irq_enable);
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			timer_ctl <= TIMER_CTL_RST;
			timer_mode_ctl <= TIMER_MODE_RST;
			timer0_low_byte <= TIMER_BYTE_RST;
			timer1_low_byte <= TIMER_BYTE_RST;
			timer0_high_byte <= TIMER_BYTE_RST;
			timer1_high_byte <= TIMER_BYTE_RST;
			clock_select_ctl <= CLOCK_SELECT_RST;
			irq_status <= IRQ_RST;
			irq_enable <= IRQ_RST;
			irq_o <= 1'b0;
		end else begin
			timer_ctl <= next_timer_ctl;
			timer_mode_ctl <= next_timer_mode_ctl;
			timer0_low_byte <= next_timer0_low_byte;
			timer1_low_byte <= next_timer1_low_byte;
			timer0_high_byte <= next_timer0_high_byte;
			timer1_high_byte <= next_timer1_high_byte;
			clock_select_ctl <= next_clock_select_ctl;
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
			irq_o <= next_irq;
		end
	end

	// ------------------------------------------------------------
	// Flag outputs
	// ------------------------------------------------------------
	assign flags_o = '{
		irq1: timer_ctl[CTL_IRQ1_DET],
		irq0: timer_ctl[CTL_IRQ0_DET],
		timer1: timer_ctl[CTL_T1_OVF],
		timer0: timer_ctl[CTL_T0_OVF]
	};

	// ------------------------------------------------------------
	// Bus slave: one wait state on every access
	// ------------------------------------------------------------
	always_comb begin
		next_waitrequest = 1'b1;
		next_readdata = avs_readdata_o;
		if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
			next_waitrequest = 1'b0;
		end
		// Data is taken in the wait cycle and stands with the answer
		if (avs_read_i & avs_waitrequest_o) begin
			// Unmapped and write-only locations read as zero
			next_readdata = 32'h0000_0000;
			unique case (avs_address_i)
				IDX_TIMER_CTL: next_readdata[7:0] = timer_ctl;
				IDX_TIMER_MODE_CTL: next_readdata[7:0] = timer_mode_ctl;
				IDX_TIMER0_LOW: next_readdata[7:0] = timer0_low_byte;
				IDX_TIMER1_LOW: next_readdata[7:0] = timer1_low_byte;
				IDX_TIMER0_HIGH: next_readdata[7:0] = timer0_high_byte;
				IDX_TIMER1_HIGH: next_readdata[7:0] = timer1_high_byte;
				IDX_CLOCK_SELECT_CTL: next_readdata[7:0] = clock_select_ctl;
				IDX_IRQ_STATUS: next_readdata[3:0] = irq_status;
				IDX_IRQ_ENABLE: next_readdata[3:0] = irq_enable;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
		end else begin
			avs_waitrequest_o <= next_waitrequest;
			avs_readdata_o <= next_readdata;
		end
	end

endmodule

// ==== verif/dtc_pin_model.sv ====
// Far-side pin driver for count inputs and interrupt lines.
// Assumes the bench asks for a low level per pin, in whole clocks.
`timescale 1ns/100ps
module dtc_pin_model
	import dtc_pkg::*;
(
	input wire logic clock_i,
	input wire logic [3:0] low_i,
	output dtc_pins_type pins_o
);
	// Lines idle high like pulled-up port pins; a request lands one edge
	// later so each level lasts at least a full clock
	always @(posedge clock_i) begin
		pins_o <= ~low_i;
	end
endmodule

// ==== verif/dtc_timer_block_props.sv ====
// Checker for the timer block: bus handshake, flags and interrupt line.
// Assumes it is bound to dtc_timer_block and sees only its ports.
`timescale 1ns/100ps
module dtc_timer_block_props
	import dtc_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire dtc_pins_type pins_i,
	input wire dtc_src_type vector_ack_i,
	input wire dtc_src_type flags_o,
	input wire logic irq_o
);
	// ----------------------------------------
	// Shadow of software-written controls
	// ----------------------------------------
	logic trig0;
	logic [3:0] en;
	logic next_trig0;
	logic [3:0] next_en;
	logic ctl_wr;
	logic en_wr;
	assign ctl_wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
		&& avs_address_i == IDX_TIMER_CTL;
	assign en_wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
		&& avs_address_i == IDX_IRQ_ENABLE;
	always_comb begin
		next_trig0 = ctl_wr ? avs_writedata_i[CTL_IRQ0_TYPE] : trig0;
		next_en = en_wr ? avs_writedata_i[3:0] : en;
	end
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			trig0 <= 1'b0;
			en <= IRQ_RST;
		end else begin
			trig0 <= next_trig0;
			en <= next_en;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	wait_single_a: assert property (
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("wait low longer than one cycle");
	wait_answer_a: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o)
		else $error("request not answered next cycle");
	read_upper_a: assert property (
		!avs_waitrequest_o && avs_read_i |-> avs_readdata_o[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	level_low_a: assert property (
		(!trig0 && !pins_i.ext_irq_pin_a)[*5] |-> flags_o.irq0)
		else $error("level flag not following low pin");
	level_high_a: assert property (
		(!trig0 && pins_i.ext_irq_pin_a)[*5] |-> !flags_o.irq0)
		else $error("level flag not following high pin");
	irq_mask_a: assert property (
		(en == 4'h0)[*2] |-> !irq_o)
		else $error("interrupt high while all masked");
	flag0_set_a: assert property (
		ctl_wr && avs_writedata_i[CTL_T0_OVF] && !vector_ack_i.timer0
		|=> flags_o.timer0)
		else $error("software set of overflow flag lost");
	// Timer 0 was just stopped by the last write, so no overflow can win
	flag0_ack_a: assert property (
		vector_ack_i.timer0 && !ctl_wr && $past(ctl_wr)
		&& !$past(avs_writedata_i[CTL_T0_RUN]) |=> !flags_o.timer0)
		else $error("overflow flag not cleared by ack");
	cover property (flags_o.timer0 && vector_ack_i.timer0);
	cover property ($rose(irq_o));
	cover property (flags_o.irq0 && trig0);
endmodule

// ==== verif/dtc_timer_block_tb.sv ====
// Self-checking bench for the dual timer block.
// Assumes dtc_pin_model drives the pins and the props checker is bound.
`timescale 1ns/100ps
module dtc_timer_block_tb
	import dtc_pkg::*;
;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic wreq;
	logic [3:0] low = 4'h0;
	dtc_pins_type pins;
	dtc_src_type ack = 4'h0;
	dtc_src_type flags;
	logic irq;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	logic [7:0] th [3] = '{8'hff, 8'hff, 8'hfe};
	logic [7:0] tl [3] = '{8'h1e, 8'hde, 8'hfe};
	int k [3] = '{2, 34, 2};

	always #12.5 clock_i = ~clock_i;

	dtc_pin_model far (.clock_i(clock_i), .low_i(low), .pins_o(pins));
	dtc_timer_block dut (.clock_i(clock_i), .reset_i(reset_i),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wd), .avs_byteenable_i(4'hf),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .pins_i(pins),
		.vector_ack_i(ack), .flags_o(flags), .irq_o(irq));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic stop_test();
		if (err_total == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	// Request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clock_i);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= {24'h0, d};
		do @(posedge clock_i); while (wreq !== 1'b0);
		q = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wrt(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		check($sformatf("reg %h", a), {8'h00, q}, {8'h00, e});
	endtask
	// Count pins need a full clock high and low
	task automatic pulse(input int b);
		@(posedge clock_i);
		low[b] <= 1'b1;
		tick(2);
		low[b] <= 1'b0;
		tick(2);
	endtask
	task automatic waitflag(input int b, output int n);
		n = 0;
		while (flags[b] !== 1'b1) begin
			@(posedge clock_i);
			n++;
		end
	endtask

	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end

	initial begin
		int n;
		logic [7:0] v;
		void'($urandom(32'hb6f0));
		tick(5);
		reset_i <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			v = i == 6 ? CLOCK_SELECT_RST : 8'h00;
			rdchk(IDX_TIMER_CTL + 8'(i), v);
		end
		rdchk(8'h10, 8'h00);
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			wrt(IDX_TIMER0_LOW + 8'(i), v);
			rdchk(IDX_TIMER0_LOW + 8'(i), v);
		end
		wrt(IDX_TIMER_CTL, 8'ha0);
		tick(1);
		check("flags", 16'(flags), 16'h3);
		// Ack right after a control write that leaves timer 0 stopped
		wrt(IDX_TIMER_CTL, 8'ha0);
		ack <= 4'h1;
		tick(1);
		ack <= 4'h0;
		tick(1);
		check("flags", 16'(flags), 16'h2);
		// Modes 0 to 2 with each divider: first overflow, then the mode 2 reload period
		for (int j = 0; j < 6; j++) begin
			int m;
			int dv;
			logic hit;
			m = j % 3;
			dv = j < 3 ? 12 : 4;
			wrt(IDX_TIMER_CTL, 8'h00);
			wrt(IDX_CLOCK_SELECT_CTL, j < 3 ? 8'h01 : 8'h09);
			wrt(IDX_TIMER_MODE_CTL, 8'(m));
			wrt(IDX_TIMER0_HIGH, th[m]);
			wrt(IDX_TIMER0_LOW, tl[m]);
			wrt(IDX_TIMER_CTL, 8'h10);
			waitflag(0, n);
			hit = n >= (k[m] - 1) * dv && n <= k[m] * dv + 2;
			check("ovf", 16'(hit), 16'h1);
			if (m == 2) begin
				ack <= 4'h1;
				tick(1);
				ack <= 4'h0;
				tick(1);
				waitflag(0, n);
				check("reload period", 16'(n + 2), 16'(2 * dv));
			end
		end
		wrt(IDX_TIMER_MODE_CTL, 8'hd0);
		wrt(IDX_TIMER1_LOW, 8'h00);
		wrt(IDX_TIMER_CTL, 8'h40);
		n = 1 + int'($urandom_range(7));
		repeat (n) pulse(1);
		rdchk(IDX_TIMER1_LOW, 8'(n));
		low[3] <= 1'b1;
		tick(4);
		repeat (3) pulse(1);
		rdchk(IDX_TIMER1_LOW, 8'(n));
		low[3] <= 1'b0;
		wrt(IDX_TIMER_CTL, 8'h00);
		wrt(IDX_CLOCK_SELECT_CTL, 8'h19);
		wrt(IDX_TIMER_MODE_CTL, 8'h33);
		wrt(IDX_TIMER0_HIGH, 8'hfe);
		wrt(IDX_TIMER0_LOW, 8'h00);
		wrt(IDX_TIMER1_LOW, 8'h00);
		wrt(IDX_TIMER_CTL, 8'h40);
		waitflag(1, n);
		check("split ovf", 16'(n <= 10), 16'h1);
		rdchk(IDX_TIMER1_LOW, 8'h00);
		rdchk(IDX_TIMER0_LOW, 8'h00);
		wrt(IDX_TIMER_CTL, 8'h05);
		wrt(IDX_IRQ_CLEAR, 8'h0f);
		wrt(IDX_IRQ_ENABLE, 8'h04);
		tick(2);
		check("irq idle", 16'(irq), 16'h0);
		pulse(2);
		waitflag(2, n);
		tick(2);
		check("irq raised", 16'(irq), 16'h1);
		rdchk(IDX_IRQ_STATUS, 8'h04);
		ack <= 4'h4;
		tick(1);
		ack <= 4'h0;
		tick(1);
		check("edge flag", 16'(flags.irq0), 16'h0);
		wrt(IDX_IRQ_ENABLE, 8'h00);
		tick(2);
		check("irq masked", 16'(irq), 16'h0);
		wrt(IDX_IRQ_CLEAR, 8'h04);
		wrt(IDX_IRQ_ENABLE, 8'h04);
		tick(2);
		check("irq cleared", 16'(irq), 16'h0);
		rdchk(IDX_IRQ_STATUS, 8'h00);
		wrt(IDX_TIMER_CTL, 8'h00);
		low[2] <= 1'b1;
		tick(6);
		check("level flag", 16'(flags.irq0), 16'h1);
		low[2] <= 1'b0;
		tick(6);
		check("level flag", 16'(flags.irq0), 16'h0);
		stop_test();
	end
endmodule

bind dtc_timer_block dtc_timer_block_props props (.clock_i(clock_i),
	.reset_i(reset_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.pins_i(pins_i), .vector_ack_i(vector_ack_i), .flags_o(flags_o),
	.irq_o(irq_o));
